// [slp_checker.sv]
// segment limit and page protection checker with its control registers
`default_nettype none
module slp_checker (
    // clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    // register port
    input  wire logic [slp_pkg::SLP_ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]                   reg_wdata_i,
    input  wire logic                          reg_wr_i,
    input  wire logic                          reg_rd_i,
    output logic [31:0]                        reg_rdata_o,
    // access request and checked answer
    input  wire slp_pkg::slp_req_type          req_i,
    output slp_pkg::slp_rsp_type               rsp_o
);
    import slp_pkg::*;

    typedef struct packed {
        logic        prot_mode_enable;
        logic        paging_enable_flag;
        logic        write_protect;
        logic        long_mode_active;
        logic [15:0] global_table_reg;
        logic [15:0] interrupt_table_reg;
        logic [31:0] local_table_reg;
        logic [31:0] task_reg;
        logic [15:0] fault_cnt;
        logic [31:0] rdata;
        slp_rsp_type rsp;
    } slp_state_type;

    slp_state_type st_q;
    slp_state_type st_d;

    function automatic logic [32:0] slp_size_m1(input slp_size_type sz);
        case (sz)
            SLP_SZ_WORD:   slp_size_m1 = 33'h0_0000_0001;
            SLP_SZ_DWORD:  slp_size_m1 = 33'h0_0000_0003;
            SLP_SZ_QWORD:  slp_size_m1 = 33'h0_0000_0007;
            SLP_SZ_DQWORD: slp_size_m1 = 33'h0_0000_000F;
            default:       slp_size_m1 = 33'h0_0000_0000;
        endcase
    endfunction : slp_size_m1

    // combinational check results
    logic [19:0]   raw_lim;
    logic [31:0]   eff_lim;
    logic [32:0]   last_byte;
    logic [32:0]   tbl_byte;
    logic [31:0]   base;
    logic [31:0]   upper;
    logic          expand_down;
    logic          lim_fault;
    logic          tbl_fault;
    logic          mode_fault;
    logic          pg_fault;
    logic          cs_long;
    logic          cs_dflt;
    logic          mode64;
    logic          any_fault;

    always_comb begin
        raw_lim     = {req_i.desc[SLP_D_LIMHI +: 4], req_i.desc[15:0]};                   // see [R5]
        if (req_i.desc[SLP_D_G]) begin                                                    // see [R4]
            eff_lim = {raw_lim, SLP_GRAN_FILL};                                           // see [R16]
        end else begin
            eff_lim = {12'h000, raw_lim};                                                 // see [R15]
        end
        // expand-down applies to data descriptors only
        expand_down = req_i.desc[SLP_D_S] && !req_i.desc[SLP_D_CODE] && req_i.desc[SLP_D_E]; // see [R8]
        upper       = req_i.desc[SLP_D_DB] ? SLP_FULL_LIM : SLP_SMALL_BOUND;
        last_byte   = {1'b0, req_i.offset} + slp_size_m1(req_i.size);
        cs_long     = req_i.cs_desc_hi[SLP_D_L - SLP_HI];
        cs_dflt     = req_i.cs_desc_hi[SLP_D_DB - SLP_HI];
        mode64      = st_q.long_mode_active && cs_long;                                    // see [R10]
        base        = {req_i.desc[SLP_D_BASE_HI +: 8], req_i.desc[SLP_D_BASE_MID +: 8],
                       req_i.desc[SLP_D_BASE_LO +: 16]};
        if (mode64 && req_i.is_fetch) begin
            base = 32'h0000_0000;                                                         // see [R9]
        end
        // segment limit: done whatever the privilege levels hold
        lim_fault = 1'b0;                                                                  // see [R2]
        if (req_i.kind == SLP_ACC_SEG && !mode64) begin                                   // see [R9]
            if (expand_down) begin
                lim_fault = ({1'b0, req_i.offset} <= {1'b0, eff_lim}) ||
                            (last_byte > {1'b0, upper});                                  // see [R19]
            end else if (eff_lim != SLP_FULL_LIM) begin                                   // see [R18]
                lim_fault = last_byte > {1'b0, eff_lim};                                  // see [R17]
            end
        end
        // descriptor table and task segment limits
        tbl_byte  = {17'h0_0000, req_i.sel[15:SLP_SEL_IDX], 3'h0} + SLP_DESC_LAST;
        tbl_fault = 1'b0;
        case (req_i.kind)
            SLP_ACC_DESC: begin
                if (req_i.sel[SLP_SEL_TI]) begin
                    tbl_fault = tbl_byte > {1'b0, st_q.local_table_reg};                  // see [R21]
                end else begin
                    tbl_fault = tbl_byte > {17'h0_0000, st_q.global_table_reg};           // see [R20]
                end
            end
            SLP_ACC_GATE: begin
                tbl_fault = ({22'h00_0000, req_i.offset[7:0], 3'h0} + SLP_DESC_LAST) >
                            {17'h0_0000, st_q.interrupt_table_reg};                       // see [R20]
            end
            SLP_ACC_TASK: begin
                tbl_fault = last_byte > {1'b0, st_q.task_reg};                            // see [R21]
            end
            default: begin
                tbl_fault = 1'b0;
            end
        endcase
        mode_fault = st_q.long_mode_active && cs_long && cs_dflt;                         // see [R13]
        // page checks: open entries with write-protect clear never fault
        pg_fault = 1'b0;
        if (st_q.paging_enable_flag) begin                                                // see [R3]
            pg_fault = (req_i.user && !req_i.page_entry[SLP_PTE_US]) ||                    // see [R7]
                       (req_i.is_write && !req_i.page_entry[SLP_PTE_RW] &&
                        (req_i.user || st_q.write_protect)) ||                            // see [R22]
                       (req_i.is_fetch && req_i.page_entry[SLP_PTE_NX]);
        end
        any_fault = st_q.prot_mode_enable && (lim_fault || tbl_fault || mode_fault || pg_fault); // see [R1]
    end

    always_comb begin
        st_d = st_q;
        // register writes
        if (reg_wr_i) begin
            if (reg_addr_i == SLP_REG_CTRL) begin
                st_d.prot_mode_enable   = reg_wdata_i[SLP_CTRL_PE];                       // see [R1]
                st_d.paging_enable_flag = reg_wdata_i[SLP_CTRL_PG];                       // see [R3]
                st_d.write_protect      = reg_wdata_i[SLP_CTRL_WP];
                st_d.long_mode_active   = reg_wdata_i[SLP_CTRL_LMA];
            end else if (reg_addr_i == SLP_REG_GTBL) begin
                st_d.global_table_reg = reg_wdata_i[15:0];                                // see [R20]
            end else if (reg_addr_i == SLP_REG_ITBL) begin
                st_d.interrupt_table_reg = reg_wdata_i[15:0];
            end else if (reg_addr_i == SLP_REG_LTBL) begin
                st_d.local_table_reg = reg_wdata_i;                                       // see [R21]
            end else if (reg_addr_i == SLP_REG_TASK) begin
                st_d.task_reg = reg_wdata_i;
            end
        end
        // register reads, answer stands for one cycle only
        st_d.rdata = 32'h0000_0000;
        if (reg_rd_i) begin
            if (reg_addr_i == SLP_REG_CTRL) begin
                st_d.rdata = {28'h000_0000, st_q.long_mode_active, st_q.write_protect,
                              st_q.paging_enable_flag, st_q.prot_mode_enable};
            end else if (reg_addr_i == SLP_REG_GTBL) begin
                st_d.rdata = {16'h0000, st_q.global_table_reg};
            end else if (reg_addr_i == SLP_REG_ITBL) begin
                st_d.rdata = {16'h0000, st_q.interrupt_table_reg};
            end else if (reg_addr_i == SLP_REG_LTBL) begin
                st_d.rdata = st_q.local_table_reg;
            end else if (reg_addr_i == SLP_REG_TASK) begin
                st_d.rdata = st_q.task_reg;
            end else if (reg_addr_i == SLP_REG_STAT) begin
                st_d.rdata = {st_q.fault_cnt, 11'h000, st_q.rsp.mode64, st_q.rsp.page_fault,
                              st_q.rsp.stack_sel, st_q.rsp.fault, st_q.rsp.done};
            end
        end
        // answer to the access request, fault and grant exclusive
        st_d.rsp.done       = req_i.valid;
        st_d.rsp.fault      = req_i.valid && any_fault;                                   // see [R24]
        st_d.rsp.grant      = req_i.valid && !any_fault;                                  // see [R23]
        st_d.rsp.stack_sel  = req_i.valid && any_fault && lim_fault && !pg_fault &&
                              req_i.is_stack && !mode_fault && !tbl_fault;                // see [R17]
        st_d.rsp.page_fault = req_i.valid && any_fault && pg_fault;
        st_d.rsp.linear     = req_i.valid ? base + req_i.offset : 32'h0000_0000;
        st_d.rsp.mode64     = mode64;
        if (!st_q.long_mode_active) begin
            st_d.rsp.op_size   = cs_dflt ? SLP_AS_32 : SLP_AS_16;
            st_d.rsp.addr_size = cs_dflt ? SLP_AS_32 : SLP_AS_16;
        end else if (cs_long) begin
            st_d.rsp.op_size   = SLP_AS_32;                                               // see [R12]
            st_d.rsp.addr_size = SLP_AS_64;
        end else begin
            st_d.rsp.op_size   = cs_dflt ? SLP_AS_32 : SLP_AS_16;                         // see [R11]
            st_d.rsp.addr_size = cs_dflt ? SLP_AS_32 : SLP_AS_16;
        end
        st_d.rsp.current_priv_level    = req_i.cs_sel[1:0];                               // see [R6]
        st_d.rsp.requested_priv_level  = req_i.sel[1:0];                                  // see [R6]
        st_d.rsp.descriptor_priv_level = req_i.desc[SLP_D_DPL +: 2];                      // see [R4]
        st_d.rsp.code_priv_level       = req_i.cs_desc_hi[SLP_D_DPL - SLP_HI +: 2];       // see [R14]
        if (req_i.valid && any_fault) begin
            st_d.fault_cnt = st_q.fault_cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_q                     <= '0;                                               // see [R25]
            st_q.prot_mode_enable    <= SLP_CTRL_RST[SLP_CTRL_PE];
            st_q.paging_enable_flag  <= SLP_CTRL_RST[SLP_CTRL_PG];
            st_q.write_protect       <= SLP_CTRL_RST[SLP_CTRL_WP];
            st_q.long_mode_active    <= SLP_CTRL_RST[SLP_CTRL_LMA];
            st_q.global_table_reg    <= SLP_TBL16_RST;
            st_q.interrupt_table_reg <= SLP_TBL16_RST;
            st_q.local_table_reg     <= SLP_TBL32_RST;
            st_q.task_reg            <= SLP_TBL32_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o = st_q.rdata;
    assign rsp_o       = st_q.rsp;

    // checks
    a_prot_off_quiet: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R1]
        (!st_q.prot_mode_enable && req_i.valid) |=> (!rsp_o.fault && rsp_o.grant))
        else $error("fault raised with protection off");
    a_reset_no_fault: assert property (@(posedge clk_i) // see [R25]
        $fell(sys_rst_i) |-> (!rsp_o.fault && !st_q.prot_mode_enable && !st_q.long_mode_active))
        else $error("fault or enable present after reset");
    a_long_dflt_gp: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R13]
        (st_q.prot_mode_enable && st_q.long_mode_active && req_i.valid &&
         req_i.cs_desc_hi[SLP_D_L - SLP_HI] && req_i.cs_desc_hi[SLP_D_DB - SLP_HI])
        |=> (rsp_o.fault && !rsp_o.stack_sel))
        else $error("reserved long code combination not faulted");
    a_byte_gran_lim: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R15]
        (st_q.prot_mode_enable && req_i.valid && req_i.kind == SLP_ACC_SEG && !st_q.long_mode_active &&
         !req_i.desc[SLP_D_G] && !req_i.desc[SLP_D_E] && req_i.size == SLP_SZ_BYTE &&
         req_i.offset > {12'h000, req_i.desc[SLP_D_LIMHI +: 4], req_i.desc[15:0]}) |=> rsp_o.fault)
        else $error("byte beyond limit not faulted");
    a_page_gran_low: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R16]
        (req_i.valid && req_i.kind == SLP_ACC_SEG && req_i.desc[SLP_D_G] && req_i.desc[SLP_D_S] &&
         !req_i.desc[SLP_D_E] && req_i.desc[SLP_D_LIMHI +: 4] == 4'h0 && req_i.desc[15:0] == 16'h0000 &&
         req_i.size == SLP_SZ_BYTE && req_i.offset <= 32'h0000_0FFF && !st_q.paging_enable_flag &&
         !st_q.long_mode_active) |=> !rsp_o.fault)
        else $error("offset inside first granule faulted");
    a_stack_select: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R24]
        rsp_o.stack_sel |-> (rsp_o.fault && !rsp_o.page_fault && !rsp_o.grant))
        else $error("stack select without fault");
    a_fault_grant_x: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R23]
        rsp_o.done |-> (rsp_o.fault != rsp_o.grant))
        else $error("grant and fault not exclusive");
    a_gtbl_limit: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R20]
        (st_q.prot_mode_enable && req_i.valid && req_i.kind == SLP_ACC_DESC && !req_i.sel[SLP_SEL_TI] &&
         {req_i.sel[15:SLP_SEL_IDX], 3'h7} > st_q.global_table_reg) |=> rsp_o.fault)
        else $error("selector beyond global table accepted");
    a_open_pages: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R22]
        (req_i.valid && !st_q.write_protect && req_i.page_entry[SLP_PTE_RW] &&
         req_i.page_entry[SLP_PTE_US] && !req_i.page_entry[SLP_PTE_NX]) |=> !rsp_o.page_fault)
        else $error("open page faulted");
    a_long_addr64: assert property (@(posedge clk_i) disable iff (sys_rst_i) // see [R12]
        (req_i.valid && st_q.long_mode_active && req_i.cs_desc_hi[SLP_D_L - SLP_HI])
        |=> (rsp_o.mode64 && rsp_o.addr_size == SLP_AS_64 && rsp_o.op_size == SLP_AS_32))
        else $error("64-bit mode sizes wrong");
    a_read_one_cycle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !reg_rd_i |=> (reg_rdata_o == 32'h0000_0000))
        else $error("read data standing without read");

    c_stack_fault: cover property (@(posedge clk_i) disable iff (sys_rst_i) rsp_o.stack_sel);
    c_page_fault:  cover property (@(posedge clk_i) disable iff (sys_rst_i) rsp_o.page_fault);
    c_expand_ok:   cover property (@(posedge clk_i) disable iff (sys_rst_i)
        (req_i.valid && req_i.desc[SLP_D_E] && req_i.desc[SLP_D_S] && st_q.prot_mode_enable) ##1 rsp_o.grant);
    c_back_to_back: cover property (@(posedge clk_i) disable iff (sys_rst_i) rsp_o.fault ##1 rsp_o.grant);
endmodule : slp_checker
`default_nettype wire

// [slp_pkg.sv]
// constants and carrier types for the segment limit protection checker
// Behaviour
// [R1] protection follows prot_mode_enable, no other switch
// [R2] zero privilege levels still get limit checks
// [R3] page checks follow paging_enable_flag, no off bit
// [R4] descriptor kind, type, privilege, granularity bit positions
// [R5] limit from low 0-15 and high 16-19
// [R6] privilege levels from selector low two bits
// [R7] page bits: user 2, write 1, no-exec 63
// [R8] expand-down flag is high-word bit 10
// [R9] 64-bit mode: code base zero, limit ignored
// [R10] long-code bit 53 picks 64-bit or compatibility
// [R11] compatibility default size 16 or 32 bits
// [R12] long-code set: operand 32, address 64
// [R13] long-code and default-size both set faults
// [R14] code descriptor privilege still drives execution level
// [R15] byte granularity: 20-bit limit used directly
// [R16] page granularity: limit shifted, low 12 unchecked
// [R17] size-dependent limit fault, stack or general
// [R18] full 4-GByte limit: no size-dependent fault
// [R19] expand-down: offsets above limit up to bound
// [R20] 16-bit global and interrupt table limits enforced
// [R21] 32-bit local table and task limits enforced
// [R22] write-protect clear plus open entries: no faults
// [R23] checks finish before the memory cycle grant
// [R24] fault and stack-versus-general select together
// [R25] reset clears enables, no faults until set
`default_nettype none
package slp_pkg;
    localparam int          SLP_ADDR_W      = 4;
    localparam logic [3:0]  SLP_REG_CTRL    = 4'h0;
    localparam logic [3:0]  SLP_REG_GTBL    = 4'h1;
    localparam logic [3:0]  SLP_REG_ITBL    = 4'h2;
    localparam logic [3:0]  SLP_REG_LTBL    = 4'h3;
    localparam logic [3:0]  SLP_REG_TASK    = 4'h4;
    localparam logic [3:0]  SLP_REG_STAT    = 4'h5;
    // control register bits
    localparam int          SLP_CTRL_PE     = 0;
    localparam int          SLP_CTRL_PG     = 1;
    localparam int          SLP_CTRL_WP     = 2;
    localparam int          SLP_CTRL_LMA    = 3;
    localparam logic [3:0]  SLP_CTRL_RST    = 4'h0;
    localparam logic [15:0] SLP_TBL16_RST   = 16'hFFFF;
    localparam logic [31:0] SLP_TBL32_RST   = 32'h0000_0000;
    // descriptor field positions within the 64-bit descriptor
    localparam int          SLP_HI          = 32;
    localparam int          SLP_D_S         = SLP_HI + 12;
    localparam int          SLP_D_TYPE      = SLP_HI + 8;
    localparam int          SLP_D_CODE      = SLP_HI + 11;
    localparam int          SLP_D_E         = SLP_HI + 10;
    localparam int          SLP_D_DPL       = SLP_HI + 13;
    localparam int          SLP_D_LIMHI     = SLP_HI + 16;
    localparam int          SLP_D_G         = SLP_HI + 23;
    localparam int          SLP_D_DB        = SLP_HI + 22;
    localparam int          SLP_D_L         = 53;
    localparam int          SLP_D_BASE_LO   = 16;
    localparam int          SLP_D_BASE_MID  = SLP_HI + 0;
    localparam int          SLP_D_BASE_HI   = SLP_HI + 24;
    localparam int          SLP_SEL_TI      = 2;
    localparam int          SLP_SEL_IDX     = 3;
    // paging entry bits
    localparam int          SLP_PTE_RW      = 1;
    localparam int          SLP_PTE_US      = 2;
    localparam int          SLP_PTE_NX      = 63;
    localparam int          SLP_GRAN_SH     = 12;
    localparam logic [11:0] SLP_GRAN_FILL   = 12'hFFF;
    localparam logic [31:0] SLP_FULL_LIM    = 32'hFFFF_FFFF;
    localparam logic [31:0] SLP_SMALL_BOUND = 32'h0000_FFFF;
    localparam logic [32:0] SLP_DESC_LAST   = 33'h0_0000_0007;

    typedef enum logic [2:0] {SLP_SZ_BYTE, SLP_SZ_WORD, SLP_SZ_DWORD, SLP_SZ_QWORD, SLP_SZ_DQWORD} slp_size_type;
    typedef enum logic [1:0] {SLP_ACC_SEG, SLP_ACC_DESC, SLP_ACC_GATE, SLP_ACC_TASK} slp_kind_type;
    typedef enum logic [1:0] {SLP_AS_16, SLP_AS_32, SLP_AS_64} slp_asize_type;

    typedef struct packed {
        logic         valid;
        slp_kind_type kind;
        logic [63:0]  desc;
        logic [31:0]  cs_desc_hi;
        logic [15:0]  cs_sel;
        logic [15:0]  sel;
        logic [31:0]  offset;
        slp_size_type size;
        logic         is_stack;
        logic         is_fetch;
        logic         is_write;
        logic         user;
        logic [63:0]  page_entry;
    } slp_req_type;

    typedef struct packed {
        logic          done;
        logic          grant;
        logic          fault;
        logic          stack_sel;
        logic          page_fault;
        logic [31:0]   linear;
        logic          mode64;
        slp_asize_type op_size;
        slp_asize_type addr_size;
        logic [1:0]    current_priv_level;
        logic [1:0]    requested_priv_level;
        logic [1:0]    descriptor_priv_level;
        logic [1:0]    code_priv_level;
    } slp_rsp_type;
endpackage : slp_pkg
`default_nettype wire

// [slp_exc_model.sv]
// exception unit stand-in that tallies fault answers of the checker
`default_nettype none
module slp_exc_model (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 sys_rst_i,
    // checked answer and tallies
    input  wire slp_pkg::slp_rsp_type rsp_i,
    output logic [15:0]               flt_cnt_o,
    output logic [15:0]               ss_cnt_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import slp_pkg::*;
    // a fault replaces the memory cycle, so only faults are tallied
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            flt_cnt_o <= 16'h0000;
            ss_cnt_o  <= 16'h0000;
        end else if (rsp_i.done && rsp_i.fault) begin
            flt_cnt_o <= flt_cnt_o + 16'h0001;
            ss_cnt_o  <= ss_cnt_o + {15'h0000, rsp_i.stack_sel};
        end
    end
endmodule : slp_exc_model
`default_nettype wire

// [slp_checker_tb.sv]
// self-checking bench for the segment limit protection checker
`default_nettype none
module slp_checker_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import slp_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    slp_req_type req_q = '0;
    slp_req_type r = '0;
    slp_rsp_type rsp;
    logic [15:0] flt_cnt, ss_cnt;
    logic [15:0] nflt = 16'h0, nss = 16'h0;
    int num_errors = 0, n_compared = 0;
    logic [63:0] d;
    logic [31:0] o;
    always #2.5 clk = ~clk;
    slp_checker uut (.clk_i(clk), .sys_rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .req_i(req_q), .rsp_o(rsp));
    slp_exc_model exc (.clk_i(clk), .sys_rst_i(rst), .rsp_i(rsp), .flt_cnt_o(flt_cnt), .ss_cnt_o(ss_cnt));
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("register", rdata, exp);
    endtask : rd_reg
    task automatic go(input logic f, input logic pf);
        @(posedge clk);
        req_q <= r;
        @(posedge clk);
        req_q.valid <= 1'b0;
        #1;
        chk("answer", {27'h0, rsp.done, rsp.grant, rsp.fault, rsp.stack_sel, rsp.page_fault},
            {27'h0, 1'b1, !f, f, f & r.is_stack & !pf, pf});
        nflt += {15'h0, f};
        nss += {15'h0, f & r.is_stack & !pf};
    endtask : go
    task automatic seg(input logic [63:0] dv, input logic [31:0] ov, input slp_size_type s, input logic f);
        r.kind = SLP_ACC_SEG;
        r.desc = dv;
        r.offset = ov;
        r.size = s;
        go(f, 1'b0);
    endtask : seg
    task automatic tbl(input slp_kind_type k, input logic [15:0] s, input logic [31:0] ov, input logic f);
        r.kind = k;
        r.sel = s;
        r.offset = ov;
        r.size = SLP_SZ_DWORD;
        go(f, 1'b0);
    endtask : tbl
    task automatic pg(input logic [63:0] e, input logic u, w, x, input logic pf);
        r.page_entry = e;
        r.user = u;
        r.is_write = w;
        r.is_fetch = x;
        r.kind = SLP_ACC_SEG;
        r.desc = mk(20'hFFFFF, 1'b1, 1'b0, 1'b0, 2'h0);
        r.offset = 32'h0;
        r.size = SLP_SZ_BYTE;
        go(pf, pf);
    endtask : pg
    function automatic logic [63:0] mk(input logic [19:0] l, input logic g, e, b, input logic [1:0] p);
        mk = 64'h0000_8200_0000_0000;
        mk[15:0] = l[15:0];
        mk[51:48] = l[19:16];
        mk[44] = 1'b1;
        mk[42] = e;
        mk[46:45] = p;
        mk[54] = b;
        mk[55] = g;
    endfunction : mk
    task automatic wrap_up;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        wrap_up();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        r.valid = 1'b1;
        wr_reg(4'h5, 32'hFFFF_FFFF);
        wr_reg(4'hC, 32'hFFFF_FFFF);
        for (int i = 0; i < 8; i++) rd_reg(4'(i), (i == 1 || i == 2) ? 32'hFFFF : 32'h0);
        seg(mk(20'h0, 1'b0, 1'b0, 1'b0, 2'h0), 32'h1000, SLP_SZ_DWORD, 1'b0);
        wr_reg(SLP_REG_CTRL, 32'h1);
        d = mk(20'h00100, 1'b0, 1'b0, 1'b0, 2'h0);
        for (int i = 0; i < 5; i++) begin
            o = 32'h100 - ((32'h1 << i) - 32'h1);
            r.is_stack = i[0];
            seg(d, o, slp_size_type'(i), 1'b0);
            seg(d, o + 32'h1, slp_size_type'(i), 1'b1);
        end
        r.is_stack = 1'b0;
        d = mk(20'h0, 1'b1, 1'b0, 1'b0, 2'h0);
        seg(d, 32'hFFC, SLP_SZ_DWORD, 1'b0);
        seg(d, 32'hFFF, SLP_SZ_BYTE, 1'b0);
        seg(d, 32'hFFD, SLP_SZ_DWORD, 1'b1);
        seg(mk(20'hFFFFF, 1'b1, 1'b0, 1'b0, 2'h0), 32'hFFFF_FFFF, SLP_SZ_DWORD, 1'b0);
        d = mk(20'h00010, 1'b0, 1'b1, 1'b0, 2'h0);
        seg(d, 32'h10, SLP_SZ_BYTE, 1'b1);
        seg(d, 32'h11, SLP_SZ_BYTE, 1'b0);
        seg(d, 32'hFFFF, SLP_SZ_WORD, 1'b1);
        seg(mk(20'h00010, 1'b0, 1'b1, 1'b1, 2'h0), 32'h1_0000, SLP_SZ_WORD, 1'b0);
        wr_reg(SLP_REG_GTBL, 32'hF);
        wr_reg(SLP_REG_LTBL, 32'h17);
        wr_reg(SLP_REG_ITBL, 32'hF);
        wr_reg(SLP_REG_TASK, 32'h67);
        tbl(SLP_ACC_DESC, 16'h0008, 32'h0, 1'b0);
        tbl(SLP_ACC_DESC, 16'h0010, 32'h0, 1'b1);
        tbl(SLP_ACC_DESC, 16'h0014, 32'h0, 1'b0);
        tbl(SLP_ACC_DESC, 16'h001C, 32'h0, 1'b1);
        tbl(SLP_ACC_GATE, 16'h0, 32'h1, 1'b0);
        tbl(SLP_ACC_GATE, 16'h0, 32'h2, 1'b1);
        tbl(SLP_ACC_TASK, 16'h0, 32'h64, 1'b0);
        tbl(SLP_ACC_TASK, 16'h0, 32'h65, 1'b1);
        wr_reg(SLP_REG_CTRL, 32'h9);
        r.sel = 16'h0013;
        r.cs_sel = 16'h0009;
        r.cs_desc_hi = 32'h0020_6000;
        d = mk(20'h00010, 1'b0, 1'b0, 1'b0, 2'h2);
        d[39:32] = 8'h01;
        r.is_fetch = 1'b1;
        seg(d, 32'h500, SLP_SZ_BYTE, 1'b0);
        chk("linear", rsp.linear, 32'h500);
        chk("mode", {rsp.mode64, rsp.op_size, rsp.addr_size}, {1'b1, SLP_AS_32, SLP_AS_64});
        chk("priv", {rsp.current_priv_level, rsp.requested_priv_level, rsp.descriptor_priv_level,
            rsp.code_priv_level}, 32'h7B);
        r.cs_desc_hi = 32'h0060_0000;
        seg(d, 32'h0, SLP_SZ_BYTE, 1'b1);
        r.cs_desc_hi = 32'h0;
        seg(d, 32'h11, SLP_SZ_BYTE, 1'b1);
        chk("mode", {rsp.mode64, rsp.op_size, rsp.addr_size}, {1'b0, SLP_AS_16, SLP_AS_16});
        r.cs_desc_hi = 32'h0040_0000;
        seg(d, 32'h0, SLP_SZ_BYTE, 1'b0);
        chk("linear", rsp.linear, 32'h0001_0000);
        chk("mode", {rsp.mode64, rsp.op_size, rsp.addr_size}, {1'b0, SLP_AS_32, SLP_AS_32});
        r.cs_desc_hi = 32'h0;
        wr_reg(SLP_REG_CTRL, 32'h1);
        pg(64'h0, 1'b1, 1'b1, 1'b0, 1'b0);
        wr_reg(SLP_REG_CTRL, 32'h3);
        pg(64'h2, 1'b1, 1'b0, 1'b0, 1'b1);
        pg(64'h4, 1'b1, 1'b1, 1'b0, 1'b1);
        pg(64'h0, 1'b0, 1'b1, 1'b0, 1'b0);
        pg(64'h8000_0000_0000_0006, 1'b0, 1'b0, 1'b1, 1'b1);
        pg(64'h6, 1'b1, 1'b1, 1'b0, 1'b0);
        wr_reg(SLP_REG_CTRL, 32'h7);
        pg(64'h0, 1'b0, 1'b1, 1'b0, 1'b1);
        pg(64'h6, 1'b1, 1'b0, 1'b0, 1'b0);
        rd_reg(SLP_REG_STAT, {nflt, 16'h0000});
        chk("tally", {flt_cnt, ss_cnt}, {nflt, nss});
        wrap_up();
    end
endmodule : slp_checker_tb
`default_nettype wire
